/* rtl/tci_consts.vh */
// Contract
// - Address pin picks 0x4A or 0x4B
// - First byte: address bits 7..1, direction bit 0
// - Two pointer bytes, low first, stored
// - Data bytes stored at pointer, then incrementing
// - Write STOP restores pointer to start
// - High address top bit requests checksum
// - CRC mismatch never blocks writes
// - Read after pointer write; NACK restores pointer
// - Pointer advances on every read byte
// - Message area reads wrap for continuous fetch
// - No bus traffic for 25 ms after power-up
// - Software reset: done within 25 ms, alert, flag
// - Boot configuration checksum mismatch sets error
// - Alert line floats about 100 ms after reset
// - Failed pin self test halts until reset
// - Global recalibration on listed triggers
// - Status message on calibration start and end
// - Alert asserted while data is pending
// - Alert is active low, open drain
`ifndef TCI_CONSTS_VH
`define TCI_CONSTS_VH

// ==========================================
// Bus addressing
`define TCI_ADDR_LOW 7'h4a
`define TCI_ADDR_HIGH 7'h4b
`define TCI_CKS_BIT 7
`define TCI_CRC_POLY 8'h07
`define TCI_CRC_INIT 8'h00

// ==========================================
// Message area window
`define TCI_MSG_BASE 16'h0100
`define TCI_MSG_END 16'h010a

// ==========================================
// Timing
`define TCI_CLK_HZ 200000000
`define TCI_RST_MIN_NS 90
`define TCI_ACQ_MAX_US 7750
`define TCI_BOOT_MS 25
`define TCI_FLOAT_MS 100
// Cycle counts sized to the 25-bit boot counters: 25 ms and 100 ms at 200 MHz
`define TCI_BOOT_CYC 25'd5000000
`define TCI_FLOAT_CYC 25'd20000000

// ==========================================
// Write buffer
`define TCI_FIFO_W 24
`define TCI_FIFO_D 16
`define TCI_FIFO_AW 4

`endif

/* rtl/tci_port.v */
`include "tci_consts.vh"

// ==========================================
// Write buffer
module tci_fifo #(
  parameter W = `TCI_FIFO_W,
  parameter D = `TCI_FIFO_D,
  parameter AW = `TCI_FIFO_AW
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; only the pointers and the fill count carry state
  always @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  // Pointers and fill level
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ==========================================
// Host port
module tci_port #(
  parameter [24:0] BOOT_CYC = `TCI_BOOT_CYC,
  parameter [24:0] FLOAT_CYC = `TCI_FLOAT_CYC
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Pins
  input wire address_select_pin,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  output reg change_alert_line_o,
  output reg change_alert_line_oe,
  // Memory write stream
  output reg wr_valid,
  input wire wr_ready,
  output wire [15:0] wr_addr,
  output wire [7:0] wr_data,
  // Memory read
  output reg [15:0] rd_addr,
  input wire [7:0] rd_data,
  // Core control
  input wire sw_reset,
  input wire self_test_fail,
  input wire [7:0] cfg_sum_calc,
  input wire [7:0] cfg_sum_saved,
  input wire status_read,
  input wire msg_pending,
  // Calibration triggers and completion
  input wire chan_enable,
  input wire hold_timeout,
  input wire anti_touch,
  input wire recal_cmd,
  input wire cfg_change,
  input wire cal_done,
  // Status
  output reg ready,
  output reg halted,
  output reg reset_flag,
  output reg cfg_error,
  output reg crc_error,
  output reg cal_req,
  output reg cal_start_msg,
  output reg cal_end_msg
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_RX = 3'd1;
  localparam [2:0] S_ACK = 3'd2;
  localparam [2:0] S_TX = 3'd3;
  localparam [2:0] S_MACK = 3'd4;

  // Bitwise CRC, most significant bit first
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] r;
    begin
      r = c ^ d;
      for (i = 0; i < 8; i = i + 1) begin
        r = r[7] ? ((r << 1) ^ `TCI_CRC_POLY) : (r << 1);
      end
      crc8 = r;
    end
  endfunction

  // Next read location, folding back inside the message area
  function [15:0] next_ptr;
    input [15:0] p;
    begin
      next_ptr = (p == `TCI_MSG_END) ? `TCI_MSG_BASE : p + 16'h0001;
    end
  endfunction

  reg [2:0] meta_q;
  reg [2:0] sync_q;
  reg scl_p_q;
  reg sda_p_q;
  reg [24:0] boot_cnt_q;
  reg [24:0] float_cnt_q;
  reg released_q;
  reg [6:0] dev_addr_q;
  reg cal_busy_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;
  reg first_q;
  reg rw_q;
  reg [1:0] idx_q;
  reg [7:0] lo_q;
  reg [15:0] start_q;
  reg cks_q;
  reg [7:0] crc_q;
  reg [7:0] held_q;
  reg held_v_q;
  reg push_q;
  reg [23:0] push_w_q;
  reg [23:0] wr_word_q;
  wire scl_s;
  wire sda_s;
  wire scl_r;
  wire scl_f;
  wire start_c;
  wire stop_c;
  wire boot_done;
  wire live;
  wire addr_hit;
  wire need_push;
  wire f_in_ready;
  wire f_out_valid;
  wire [23:0] f_out_data;
  wire drain;
  wire trig;

  assign scl_s = sync_q[1];
  assign sda_s = sync_q[2];
  assign scl_r = scl_s & ~scl_p_q;
  assign scl_f = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign boot_done = !ready && (boot_cnt_q == BOOT_CYC - 25'd1);
  assign live = ready & ~halted;
  assign addr_hit = (sh_q[7:1] == dev_addr_q);
  // Checksum mode holds one byte back until it is known not to be the CRC
  assign need_push = !cks_q | held_v_q;
  assign drain = ~wr_valid | wr_ready;
  assign trig = chan_enable | hold_timeout | anti_touch | recal_cmd | cfg_change;
  assign wr_addr = wr_word_q[23:8];
  assign wr_data = wr_word_q[7:0];

  // Pins pass two flip-flops before use
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      meta_q <= {sda_i, scl_i, address_select_pin};
      sync_q <= meta_q;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // ==========================================
  // Start-up sequence
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_cnt_q <= 25'h0000000;
      float_cnt_q <= 25'h0000000;
      ready <= 1'b0;
      released_q <= 1'b0;
      halted <= 1'b0;
      dev_addr_q <= `TCI_ADDR_LOW;
      reset_flag <= 1'b0;
      cfg_error <= 1'b0;
    end else if (sw_reset) begin
      boot_cnt_q <= 25'h0000000;
      float_cnt_q <= 25'h0000000;
      ready <= 1'b0;
      released_q <= 1'b0;
      halted <= 1'b0;
    end else begin
      if (!ready) begin
        boot_cnt_q <= boot_cnt_q + 25'd1;
      end
      if (!released_q) begin
        float_cnt_q <= float_cnt_q + 25'd1;
        released_q <= (float_cnt_q == FLOAT_CYC - 25'd1);
      end
      if (boot_done) begin
        ready <= 1'b1;
        dev_addr_q <= sync_q[0] ? `TCI_ADDR_HIGH : `TCI_ADDR_LOW;
        halted <= self_test_fail;
      end
      reset_flag <= boot_done | (reset_flag & ~status_read);
      cfg_error <= (boot_done && (cfg_sum_calc != cfg_sum_saved)) |
                   (cfg_error & ~status_read);
    end
  end

  // ==========================================
  // Calibration and alert
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_req <= 1'b0;
      cal_busy_q <= 1'b0;
      cal_start_msg <= 1'b0;
      cal_end_msg <= 1'b0;
      change_alert_line_o <= 1'b0;
      change_alert_line_oe <= 1'b0;
    end else begin
      cal_req <= (boot_done & ~self_test_fail) | (live & trig);
      cal_start_msg <= (boot_done & ~self_test_fail) | (live & trig);
      cal_end_msg <= cal_busy_q & cal_done;
      cal_busy_q <= cal_req | (cal_busy_q & ~cal_done);
      change_alert_line_o <= 1'b0;
      change_alert_line_oe <= released_q & live & ~sw_reset & (msg_pending | reset_flag);
    end
  end

  // ==========================================
  // Bus engine
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      first_q <= 1'b0;
      rw_q <= 1'b0;
      idx_q <= 2'h0;
      lo_q <= 8'h00;
      start_q <= 16'h0000;
      rd_addr <= 16'h0000;
      cks_q <= 1'b0;
      crc_q <= `TCI_CRC_INIT;
      held_q <= 8'h00;
      held_v_q <= 1'b0;
      push_q <= 1'b0;
      push_w_q <= 24'h000000;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      crc_error <= 1'b0;
    end else begin
      push_q <= 1'b0;
      crc_error <= 1'b0;
      sda_o <= 1'b0;
      if (!live || sw_reset) begin
        st_q <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (start_c) begin
        st_q <= S_RX;
        bit_q <= 4'h0;
        first_q <= 1'b1;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        st_q <= S_IDLE;
        sda_oe <= 1'b0;
        if (!rw_q) begin
          rd_addr <= start_q;
          // report only; data already passed on
          crc_error <= cks_q & held_v_q & (held_q != crc_q);
          held_v_q <= 1'b0;
        end
      end else begin
        case (st_q)
          S_RX: begin
            if (scl_r) begin
              sh_q <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end else if (scl_f && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              st_q <= S_ACK;
              first_q <= 1'b0;
              if (first_q) begin
                if (addr_hit) begin
                  sda_oe <= 1'b1;
                  rw_q <= sh_q[0];
                  idx_q <= 2'h0;
                end else begin
                  st_q <= S_IDLE;
                end
              end else if (idx_q == 2'h0) begin
                sda_oe <= 1'b1;
                lo_q <= sh_q;
                crc_q <= crc8(`TCI_CRC_INIT, sh_q);
                idx_q <= 2'h1;
              end else if (idx_q == 2'h1) begin
                sda_oe <= 1'b1;
                rd_addr <= {1'b0, sh_q[6:0], lo_q};
                start_q <= {1'b0, sh_q[6:0], lo_q};
                cks_q <= sh_q[`TCI_CKS_BIT];
                crc_q <= crc8(crc_q, sh_q);
                held_v_q <= 1'b0;
                idx_q <= 2'h2;
              end else if (!need_push || f_in_ready) begin
                // A full buffer turns into a NACK, pushing back on the master
                sda_oe <= 1'b1;
                if (cks_q) begin
                  // last byte is taken as the CRC
                  held_q <= sh_q;
                  held_v_q <= 1'b1;
                end
                if (need_push) begin
                  push_q <= 1'b1;
                  push_w_q <= {rd_addr, cks_q ? held_q : sh_q};
                  rd_addr <= rd_addr + 16'h0001;
                  if (cks_q) begin
                    crc_q <= crc8(crc_q, held_q);
                  end
                end
              end
            end
          end
          S_ACK: begin
            if (scl_f) begin
              if (rw_q) begin
                // First read byte goes out on this falling edge
                tx_q <= {rd_data[6:0], 1'b0};
                sda_oe <= ~rd_data[7];
                rd_addr <= next_ptr(rd_addr);
                bit_q <= 4'h1;
                st_q <= S_TX;
              end else begin
                sda_oe <= 1'b0;
                st_q <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_f) begin
              if (bit_q == 4'h8) begin
                sda_oe <= 1'b0;
                st_q <= S_MACK;
              end else begin
                sda_oe <= ~tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          S_MACK: begin
            if (scl_r && sda_s) begin
              rd_addr <= start_q;
              st_q <= S_IDLE;
            end else if (scl_f) begin
              tx_q <= {rd_data[6:0], 1'b0};
              sda_oe <= ~rd_data[7];
              rd_addr <= next_ptr(rd_addr);
              bit_q <= 4'h1;
              st_q <= S_TX;
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================
  // Write stream buffer and output stage
  tci_fifo #(
    .W(`TCI_FIFO_W),
    .D(`TCI_FIFO_D),
    .AW(`TCI_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push_q),
    .in_ready(f_in_ready),
    .in_data(push_w_q),
    .out_valid(f_out_valid),
    .out_ready(drain),
    .out_data(f_out_data)
  );

  // Registered output so the stream ports come from flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_valid <= 1'b0;
      wr_word_q <= 24'h000000;
    end else if (drain) begin
      wr_valid <= f_out_valid;
      if (f_out_valid) begin
        wr_word_q <= f_out_data;
      end
    end
  end
endmodule

/* testbench/tci_port_asserts.sv */
// ======
// Port checker
module tci_port_asserts #(
  parameter [24:0] BOOT_CYC = 25'h0c8,
  parameter [24:0] FLOAT_CYC = 25'h190
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Pins
  input wire sda_oe,
  input wire change_alert_line_o,
  input wire change_alert_line_oe,
  // Write stream
  input wire wr_valid,
  input wire wr_ready,
  input wire [15:0] wr_addr,
  input wire [7:0] wr_data,
  // Core control
  input wire sw_reset,
  input wire [7:0] cfg_sum_calc,
  input wire [7:0] cfg_sum_saved,
  input wire msg_pending,
  input wire chan_enable,
  input wire hold_timeout,
  input wire anti_touch,
  input wire recal_cmd,
  input wire cfg_change,
  input wire cal_done,
  // Status
  input wire ready,
  input wire halted,
  input wire reset_flag,
  input wire cfg_error,
  input wire cal_req,
  input wire cal_start_msg,
  input wire cal_end_msg
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [25:0] up_q;
  wire [25:0] up_d;
  wire trig;
  // Saturate a little past the float window so the alert check stays decided
  assign up_d = (up_q > {1'b0, FLOAT_CYC} + 26'h8) ? up_q : up_q + 26'h1;
  assign trig = chan_enable | hold_timeout | anti_touch | recal_cmd | cfg_change;
  // Edges since reset release; software reset restarts it like a boot
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_q <= 26'h0;
    end else if (sw_reset) begin
      up_q <= 26'h0;
    end else begin
      up_q <= up_d;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  AST_ALERT_OD: assert property (change_alert_line_o == 1'b0)
    else $error("alert data not low");
  AST_ALERT_FLOAT: assert property ((up_q + 26'h2 < FLOAT_CYC) |-> !change_alert_line_oe)
    else $error("alert driven in float window");
  AST_QUIET_BOOT: assert property (!ready |-> !sda_oe && !change_alert_line_oe)
    else $error("pins driven before ready");
  AST_BOOT_TIME: assert property ($rose(ready) |->
    (up_q + 26'h2 >= BOOT_CYC) && (up_q <= BOOT_CYC + 26'h2))
    else $error("ready at wrong time");
  AST_BOOT_FLAG: assert property ($rose(ready) |-> reset_flag && (cal_req || halted))
    else $error("boot end without flag or calibration");
  AST_CFG_CHECK: assert property ($rose(ready) && (cfg_sum_calc != cfg_sum_saved)
    |-> ##[0:1] cfg_error)
    else $error("config checksum error missed");
  AST_HALT_SILENT: assert property (halted |-> !sda_oe && !change_alert_line_oe)
    else $error("halted device drives pins");
  AST_CAL_TRIG: assert property (ready && !halted && !sw_reset && trig
    |=> cal_req && cal_start_msg)
    else $error("calibration trigger ignored");
  AST_CAL_END: assert property (cal_end_msg |-> $past(cal_done))
    else $error("end message without done");
  AST_ALERT_ON: assert property ((up_q > FLOAT_CYC + 26'h2) && ready && !halted
    && !sw_reset && msg_pending |=> change_alert_line_oe)
    else $error("alert not raised");
  AST_ALERT_OFF: assert property (!msg_pending && !reset_flag |=> !change_alert_line_oe)
    else $error("alert raised without cause");
  AST_WR_HOLD: assert property (wr_valid && !wr_ready
    |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("write word changed while stalled");
endmodule

bind tci_port tci_port_asserts #(.BOOT_CYC(BOOT_CYC), .FLOAT_CYC(FLOAT_CYC)) u_chk (
  .clk(clk), .arst_n(arst_n), .sda_oe(sda_oe), .change_alert_line_o(change_alert_line_o),
  .change_alert_line_oe(change_alert_line_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_addr(wr_addr), .wr_data(wr_data), .sw_reset(sw_reset), .cfg_sum_calc(cfg_sum_calc),
  .cfg_sum_saved(cfg_sum_saved), .msg_pending(msg_pending), .chan_enable(chan_enable),
  .hold_timeout(hold_timeout), .anti_touch(anti_touch), .recal_cmd(recal_cmd),
  .cfg_change(cfg_change), .cal_done(cal_done), .ready(ready), .halted(halted),
  .reset_flag(reset_flag), .cfg_error(cfg_error), .cal_req(cal_req),
  .cal_start_msg(cal_start_msg), .cal_end_msg(cal_end_msg));

/* testbench/tci_host_model.sv */
// ======
// Host bus master model
module tci_host_model (
  // Clock
  input wire clk,
  // Bus lines
  input wire sda,
  output logic scl = 1'b1,
  output logic sda_low = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // no acquisition setup sent
  // Wait whole system clocks; one bit is 32 of them
  task automatic q(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    q(8);
    scl <= 1'b1;
    q(16);
    sda_low <= 1'b1;
    q(16);
    scl <= 1'b0;
    q(4);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    q(8);
    scl <= 1'b1;
    q(16);
    sda_low <= 1'b0;
    q(16);
  endtask
  // Data moves only while SCL is low, a few clocks after the fall
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    q(12);
    scl <= 1'b1;
    q(16);
    r = sda;
    scl <= 1'b0;
    q(4);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
  function automatic logic [7:0] crc8(input logic [23:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
endmodule

/* testbench/tci_port_tb.sv */
// ======
// Bench for the host port
module tci_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BOOT = 800;
  localparam int FLT = 1600;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic adsel = 1'b0;
  logic wr_ready = 1'b1;
  logic sw_reset = 1'b0;
  logic stf = 1'b0;
  logic [7:0] sum_saved = 8'h5b;
  logic status_read = 1'b0;
  logic msg_pending = 1'b0;
  logic [4:0] trig = 5'h0;
  logic cal_done = 1'b0;
  wire scl, sda, sda_low, sda_o, sda_oe, alert_o, alert_oe, wr_valid, ready, halted;
  wire reset_flag, cfg_error, crc_error, cal_req, cal_start_msg, cal_end_msg;
  wire [15:0] wr_addr, rd_addr;
  wire [7:0] wr_data, rd_data;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int crc_n = 0;
  int cal_n = 0;
  int end_n = 0;
  int n0;
  logic [23:0] wq[$];
  logic [7:0] tx[$];
  logic [31:0] ak;
  logic [7:0] c;
  logic [7:0] rb;
  // Open-drain data line with its pull-up
  assign sda = !(sda_low | sda_oe);
  // Memory behind the read port: a pattern the bench can predict
  assign rd_data = rd_addr[7:0] ^ 8'h3c;
  always #2.5 clk = ~clk;
  tci_port #(.BOOT_CYC(25'd800), .FLOAT_CYC(25'd1600)) DUT (
    .clk(clk), .arst_n(arst_n), .address_select_pin(adsel), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .change_alert_line_o(alert_o),
    .change_alert_line_oe(alert_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .sw_reset(sw_reset), .self_test_fail(stf), .cfg_sum_calc(8'h5a),
    .cfg_sum_saved(sum_saved), .status_read(status_read), .msg_pending(msg_pending),
    .chan_enable(trig[0]), .hold_timeout(trig[1]), .anti_touch(trig[2]),
    .recal_cmd(trig[3]), .cfg_change(trig[4]), .cal_done(cal_done), .ready(ready),
    .halted(halted), .reset_flag(reset_flag), .cfg_error(cfg_error),
    .crc_error(crc_error), .cal_req(cal_req), .cal_start_msg(cal_start_msg),
    .cal_end_msg(cal_end_msg));
  tci_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  // Collect taken words, count pulses, and cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_valid === 1'b1 && wr_ready) wq.push_back({wr_addr, wr_data});
    if (crc_error === 1'b1) crc_n <= crc_n + 1;
    if (cal_req === 1'b1) cal_n <= cal_n + 1;
    if (cal_end_msg === 1'b1) end_n <= end_n + 1;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // START, the queued bytes, then STOP if asked; time left for the buffer
  task automatic send(input logic stp);
    logic a;
    ak = 32'h0;
    host.start();
    foreach (tx[i]) begin
      host.wr_byte(tx[i], a);
      ak[i] = a;
    end
    if (stp) host.stop();
    repeat (40) @(posedge clk);
  endtask
  // Bounded wait for the boot to end
  task automatic boot();
    repeat (4) @(posedge clk);
    for (int i = 0; i < BOOT + 40 && ready !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse_sw();
    sw_reset <= 1'b1;
    @(posedge clk);
    sw_reset <= 1'b0;
    boot();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (18) @(posedge clk);
    arst_n <= 1'b1;
    tx = '{8'h94};
    send(1'b1);
    chk("early_ack", ak[0], 0);
    chk("sda_od", sda_o, 0);
    boot();
    chk("alert_float", alert_oe, 0);
    chk("boot_flags", {ready, reset_flag, cfg_error, halted}, 4'he);
    chk("boot_cal", cal_n, 1);
    status_read <= 1'b1;
    @(posedge clk);
    status_read <= 1'b0;
    @(posedge clk);
    chk("flag_clear", {reset_flag, cfg_error}, 0);
    tx = '{8'h94, 8'h34, 8'h12, 8'ha5, 8'h5a};
    wq.delete();
    send(1'b1);
    chk("wr_ack", ak[4:0], 5'h1f);
    chk("wr_n", wq.size(), 2);
    chk("wr_0", wq[0], 24'h1234a5);
    chk("wr_1", wq[1], 24'h12355a);
    chk("ptr_back", rd_addr, 16'h1234);
    tx = '{8'h96};
    send(1'b1);
    chk("other_sla", ak[0], 0);
    for (int k = 0; k < 2; k++) begin
      c = host.crc8(24'h349296) ^ k[7:0];
      tx = '{8'h94, 8'h34, 8'h92, 8'h96, c};
      wq.delete();
      n0 = crc_n;
      send(1'b1);
      chk("cks_ack", ak[4:0], 5'h1f);
      chk("cks_err", crc_n - n0, k);
      chk("cks_n", wq.size(), 1);
      chk("cks_wr", wq[0], 24'h123496);
    end
    tx = '{8'h94, 8'h09, 8'h01};
    send(1'b1);
    host.start();
    host.wr_byte(8'h95, c[0]);
    chk("rd_sla", c[0], 1);
    for (int i = 0; i < 3; i++) begin
      host.rd_byte(i == 2, rb);
      chk("rd_byte", rb, i == 0 ? 8'h35 : i == 1 ? 8'h36 : 8'h3c);
    end
    host.stop();
    repeat (8) @(posedge clk);
    chk("rd_ptr", rd_addr, 16'h0109);
    repeat (FLT) @(posedge clk);
    msg_pending <= 1'b1;
    repeat (3) @(posedge clk);
    chk("alert_on", {alert_oe, alert_o}, 2'b10);
    msg_pending <= 1'b0;
    repeat (3) @(posedge clk);
    chk("alert_off", alert_oe, 0);
    n0 = cal_n;
    for (int i = 0; i < 5; i++) begin
      trig <= 5'h1 << i;
      @(posedge clk);
      trig <= 5'h0;
      repeat (3) @(posedge clk);
      chk("cal_req", cal_n - n0, i + 1);
    end
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cal_end", end_n, 1);
    wr_ready <= 1'b0;
    wq.delete();
    tx = '{8'h94, 8'h00, 8'h02};
    for (int i = 0; i < 18; i++) tx.push_back(i[7:0]);
    send(1'b1);
    chk("full_ack", ak[20:3], 18'h1ffff);
    chk("stall_n", wq.size(), 0);
    wr_ready <= 1'b1;
    repeat (40) @(posedge clk);
    chk("drain_n", wq.size(), 17);
    chk("drain_last", wq[16], 24'h021010);
    stf <= 1'b1;
    adsel <= 1'b1;
    sum_saved <= 8'h5a;
    pulse_sw();
    chk("halt", {halted, reset_flag, cfg_error}, 3'b110);
    tx = '{8'h96};
    send(1'b1);
    chk("halt_ack", ak[0], 0);
    stf <= 1'b0;
    pulse_sw();
    tx = '{8'h96, 8'h00, 8'h01};
    send(1'b1);
    chk("high_sla", {halted, ak[2:0]}, 4'h7);
    report_and_stop();
  end
endmodule
